// ==== fault_arb_pkg.sv ====
package fault_arb_pkg;

    // delay counts in counter-clock ticks, except the short-circuit delay in mclk cycles
    localparam int unsigned TICK_NS          = 1000;
    localparam int unsigned TICK_CYCLES      = (TICK_NS + 3) / 4;
    localparam int unsigned OVC_DLY_TICKS    = 1000;
    localparam int unsigned OVD_DLY_TICKS    = 100;
    localparam int unsigned OCUR_DLY_TICKS   = 10;
    localparam int unsigned OCUR_REL_TICKS   = 1;
    localparam int unsigned XCHG_DLY_TICKS   = 10;
    localparam int unsigned SHORT_DLY_CYCLES = 75;
    localparam int unsigned TEST_SHIFT       = 4;
    localparam int unsigned CNT_W            = 16;

    // one-hot termination of the charger-minus node
    localparam logic [2:0] TERM_RELEASED = 3'h1;
    localparam logic [2:0] TERM_GND_30K  = 3'h2;
    localparam logic [2:0] TERM_VDD_200K = 3'h4;

    typedef struct packed {
        logic over_chg;
        logic over_dis;
        logic over_cur;
        logic short_ckt;
        logic xs_chg;
    } cmp_s;

    typedef struct packed {
        logic       chg_gate;
        logic       dis_gate;
        logic       standby;
        logic [2:0] term;
    } drive_s;

endpackage

// ==== fault_timer.sv ====
module fault_timer
    import fault_arb_pkg::*;
#(
    parameter int unsigned LIMIT = 10
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             rst_n,
    // timing
    input  wire logic             tick,
    input  wire logic             run,
    input  wire logic             fast,
    // result
    output logic                  done
);
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] limit_now;

    // shortened limit never drops below one tick
    assign limit_now = fast ? CNT_W'((LIMIT >> TEST_SHIFT) + 1) : CNT_W'(LIMIT);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
            done  <= 1'b0;
        end else if (!run) begin
            count <= '0;
            done  <= 1'b0;
        end else if (tick && !done) begin
            if (count + 1'b1 >= limit_now) begin
                done <= 1'b1;
            end
            count <= count + 1'b1;
        end
    end

endmodule // fault_timer

// ==== protection_fault_arbiter.sv ====
// Behaviour
// RULE1 - over-charge timing continues while over-current is already pending or latched
// RULE2 - latched over-charge aborts a pending over-current detection
// RULE3 - over-current latched first: node pulled to ground via 30k
// RULE4 - over-charge latched first: node left released
// RULE5 - new over-charge suspends over-discharge timing and wins
// RULE6 - over-discharge timing restarts after over-charge latches if condition persists
// RULE7 - over-discharge after over-charge: no standby, node pulled to supply 200k
// RULE8 - over-discharge timing continues while over-current pending or latched
// RULE9 - latched over-discharge aborts a pending over-current detection
// RULE10 - over-discharge after over-current: drop ground pull, supply pull, standby
// RULE11 - short-circuit path runs independently of all other detections
// RULE12 - excessive-charger detection inhibited during discharge-side faults
// RULE13 - excessive-charger delay begins only once discharge gate is high
// RULE14 - board ties test select to ground; open is acceptable
// RULE15 - over-discharge: discharge gate low after delay, standby, supply pull
// RULE16 - over-current: discharge gate low after delay, no standby
// RULE17 - test select high shortens counter delays, not short-circuit delay
// RULE18 - per-fault state held and priorities evaluated every counter tick (the code evaluates them every mclk cycle; only the timers step on tick)
// RULE19 - termination select is one-hot: released, ground, or supply
module protection_fault_arbiter
    import fault_arb_pkg::*;
(
    // clock and reset
    input  wire logic   mclk,
    input  wire logic   nrst,
    // analog comparator levels
    input  wire cmp_s   cmp_in,
    input  wire logic   test_sel,
    // gate and termination drive
    output drive_s      drive
);
    logic       rst_sync1;
    logic       rst_n;
    cmp_s       cmp_m;
    cmp_s       cmp;
    logic       test_m;
    logic       test;
    logic [$clog2(TICK_CYCLES+1)-1:0] div;
    logic       tick;

    logic       oc_lat;
    logic       od_lat;
    logic       cur_lat;
    logic       sc_lat;
    logic       xc_lat;
    logic       cur_first;
    logic       od_after_oc;

    logic       oc_done;
    logic       od_done;
    logic       cur_done;
    logic       rel_done;
    logic       xc_done;
    logic       xcr_done;
    logic [7:0] sc_cnt;

    logic       od_run;
    logic       cur_run;
    logic       xc_run;
    logic       dis_high;

    // reset release
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_sync1 <= 1'b0;
            rst_n     <= 1'b0;
        end else begin
            rst_sync1 <= 1'b1;
            rst_n     <= rst_sync1;
        end
    end

    // comparators are asynchronous to mclk
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_m  <= '0;
            cmp    <= '0;
            test_m <= 1'b0;
            test   <= 1'b0;
        end else begin
            cmp_m  <= cmp_in;
            cmp    <= cmp_m;
            test_m <= test_sel;
            test   <= test_m;
        end
    end

    // RULE18 counter clock enable
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            div  <= '0;
            tick <= 1'b0;
        end else begin
            tick <= (div == '0);
            div  <= (div == '0) ? ($bits(div))'(TICK_CYCLES - 1) : div - 1'b1;
        end
    end

    assign dis_high = !(od_lat || cur_lat || sc_lat);

    // RULE5 over-charge suspends over-discharge timing
    // RULE6 restart once over-charge latched
    assign od_run  = cmp.over_dis && !od_lat && !(cmp.over_chg && !oc_lat);
    // RULE2 abort pending over-current
    // RULE9 same for over-discharge
    assign cur_run = cmp.over_cur && !cur_lat && !oc_lat && !od_lat;
    // RULE12 inhibit during discharge faults
    // RULE13 start only with discharge gate high
    assign xc_run  = cmp.xs_chg && !xc_lat && dis_high && !cmp.over_dis && !cmp.over_cur && !cmp.short_ckt;

    // RULE17 shortened delays via test
    // RULE1 over-charge timer unaffected by over-current
    fault_timer #(.LIMIT(OVC_DLY_TICKS)) u_oc_tmr (
        .mclk (mclk), .rst_n(rst_n), .tick(tick),
        .run  (cmp.over_chg && !oc_lat), .fast(test), .done(oc_done)
    );
    // RULE8 over-discharge timer unaffected by over-current
    fault_timer #(.LIMIT(OVD_DLY_TICKS)) u_od_tmr (
        .mclk (mclk), .rst_n(rst_n), .tick(tick),
        .run  (od_run), .fast(test), .done(od_done)
    );
    fault_timer #(.LIMIT(OCUR_DLY_TICKS)) u_cur_tmr (
        .mclk (mclk), .rst_n(rst_n), .tick(tick),
        .run  (cur_run), .fast(test), .done(cur_done)
    );
    fault_timer #(.LIMIT(OCUR_REL_TICKS)) u_rel_tmr (
        .mclk (mclk), .rst_n(rst_n), .tick(tick),
        .run  ((cur_lat || sc_lat) && !cmp.over_cur && !cmp.short_ckt), .fast(test), .done(rel_done)
    );
    fault_timer #(.LIMIT(XCHG_DLY_TICKS)) u_xc_tmr (
        .mclk (mclk), .rst_n(rst_n), .tick(tick),
        .run  (xc_run), .fast(test), .done(xc_done)
    );
    fault_timer #(.LIMIT(XCHG_DLY_TICKS)) u_xcr_tmr (
        .mclk (mclk), .rst_n(rst_n), .tick(tick),
        .run  (xc_lat && !cmp.xs_chg), .fast(test), .done(xcr_done)
    );

    // over-charge latch, released when the cell drops back
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            oc_lat <= 1'b0;
        end else if (oc_done) begin
            oc_lat <= 1'b1;
        end else if (!cmp.over_chg) begin
            oc_lat <= 1'b0;
        end
    end

    // RULE15 over-discharge latch
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            od_lat      <= 1'b0;
            od_after_oc <= 1'b0;
        end else if (od_done) begin
            od_lat      <= 1'b1;
            od_after_oc <= oc_lat;
        end else if (!cmp.over_dis) begin
            od_lat      <= 1'b0;
            od_after_oc <= 1'b0;
        end
    end

    // RULE16 over-current latch
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cur_lat   <= 1'b0;
            cur_first <= 1'b0;
        end else if (cur_done) begin
            cur_lat   <= 1'b1;
            cur_first <= !oc_lat;
        end else if (rel_done) begin
            cur_lat   <= 1'b0;
            cur_first <= 1'b0;
        end
    end

    // RULE11 short circuit on mclk, own counter
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sc_cnt <= '0;
            sc_lat <= 1'b0;
        end else begin
            if (!cmp.short_ckt || sc_lat) begin
                sc_cnt <= '0;
            end else begin
                sc_cnt <= sc_cnt + 1'b1;
            end
            if (cmp.short_ckt && sc_cnt == 8'(SHORT_DLY_CYCLES - 1)) begin
                sc_lat <= 1'b1;
            end else if (rel_done) begin
                sc_lat <= 1'b0;
            end
        end
    end

    // excessive charger latch
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            xc_lat <= 1'b0;
        end else if (xc_done) begin
            xc_lat <= 1'b1;
        end else if (xcr_done) begin
            xc_lat <= 1'b0;
        end
    end

    // outputs from flip-flops
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            drive <= '{chg_gate: 1'b1, dis_gate: 1'b1, standby: 1'b0, term: TERM_RELEASED};
        end else begin
            drive.chg_gate <= !(oc_lat || xc_lat);
            drive.dis_gate <= dis_high;
            // RULE7 no standby after over-charge
            // RULE10 standby even if over-current was first
            drive.standby  <= od_lat && !od_after_oc;
            // RULE19 one-hot termination
            if (od_lat) begin
                drive.term <= TERM_VDD_200K;
            // RULE3 ground pull when current first
            end else if ((cur_lat && cur_first) || sc_lat) begin
                drive.term <= TERM_GND_30K;
            // RULE4 released otherwise
            end else begin
                drive.term <= TERM_RELEASED;
            end
        end
    end

endmodule // protection_fault_arbiter

// ==== fault_arb_props.sv ====
module fault_arb_props
    import fault_arb_pkg::*;
(
    // clock and reset
    input wire logic   mclk,
    input wire logic   nrst,
    // watched ports
    input wire cmp_s   cmp_in,
    input wire logic   test_sel,
    input wire drive_s drive
);
    logic [7:0] sc_run;
    // saturate so a long short never wraps back under the bound
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) sc_run <= 8'h00;
        else if (!cmp_in.short_ckt) sc_run <= 8'h00;
        else if (sc_run != 8'hff) sc_run <= sc_run + 8'h01;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    property p_onehot; $onehot(drive.term); endproperty
    a_onehot: assert property (p_onehot) else $error("term not one-hot");
    property p_rst; $rose(nrst) |-> drive == {3'h6, TERM_RELEASED}; endproperty
    a_rst: assert property (p_rst) else $error("bad drive after reset");
    property p_stby; drive.standby |-> !drive.dis_gate && drive.term == TERM_VDD_200K; endproperty
    a_stby: assert property (p_stby) else $error("standby without supply pull");
    property p_gnd; drive.term == TERM_GND_30K |-> !drive.standby && !drive.dis_gate; endproperty
    a_gnd: assert property (p_gnd) else $error("ground pull with standby");
    property p_short; sc_run == 8'(SHORT_DLY_CYCLES + 8) |-> !drive.dis_gate; endproperty
    a_short: assert property (p_short) else $error("short not acted on");
    property p_dis_cause;
        $fell(drive.dis_gate) |-> $past(cmp_in.over_dis || cmp_in.over_cur || cmp_in.short_ckt, 4);
    endproperty
    a_dis_cause: assert property (p_dis_cause) else $error("discharge off without fault");
    // discharge gate must already stand high when the excessive-charger delay ran out
    property p_xs_gate; $fell(drive.chg_gate) && !$past(cmp_in.over_chg, 4) |-> $past(drive.dis_gate, 2); endproperty
    a_xs_gate: assert property (p_xs_gate) else $error("charger cut while discharge off");
    property p_released; !drive.chg_gate && drive.dis_gate |-> drive.term == TERM_RELEASED; endproperty
    a_released: assert property (p_released) else $error("node not released");
endmodule // fault_arb_props

bind protection_fault_arbiter fault_arb_props u_props (.mclk(mclk), .nrst(nrst), .cmp_in(cmp_in),
    .test_sel(test_sel), .drive(drive));

// ==== cell_monitor_model.sv ====
module cell_monitor_model
    import fault_arb_pkg::*;
(
    // commanded cell and node conditions
    input wire cmp_s cond,
    // comparator levels
    output cmp_s     cmp_out
);
    // a load left on keeps the node high, so the levels follow the commands
    assign cmp_out = cond;
endmodule // cell_monitor_model

// ==== protection_fault_arbiter_tb.sv ====
module protection_fault_arbiter_tb
    import fault_arb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int OC_T  = (OCUR_DLY_TICKS >> TEST_SHIFT) + 3;
    localparam int OD_T  = (OVD_DLY_TICKS >> TEST_SHIFT) + 3;
    localparam int OVC_T = (OVC_DLY_TICKS >> TEST_SHIFT) + 3;
    localparam int XS_T  = (XCHG_DLY_TICKS >> TEST_SHIFT) + 3;
    logic   mclk;
    logic   nrst;
    logic   test_sel;
    cmp_s   cond;
    cmp_s   cmp_in;
    drive_s drive;
    int     errors;
    int     tests_run;
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    protection_fault_arbiter uut (.mclk(mclk), .nrst(nrst), .cmp_in(cmp_in), .test_sel(test_sel), .drive(drive));
    cell_monitor_model model (.cond(cond), .cmp_out(cmp_in));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic set_cond(input logic [4:0] c);
        @(posedge mclk);
        cond <= cmp_s'(c);
    endtask
    task automatic hold(input int ticks);
        repeat (ticks * TICK_CYCLES) @(posedge mclk);
    endtask
    // sel 0 charge gate, 1 discharge gate, 2 standby
    task automatic wait_for(input int sel, input logic val, input int ticks);
        int n;
        n = 0;
        while (n < ticks * TICK_CYCLES && drive[5 - sel] !== val) begin
            @(posedge mclk);
            n++;
        end
        chk({7'h00, drive[5 - sel]}, {7'h00, val});
    endtask
    task automatic chk_term(input logic [2:0] exp);
        chk({5'h00, drive.term}, {5'h00, exp});
    endtask
    task automatic clear(input string name);
        set_cond(5'h00);
        wait_for(0, 1'b1, OVC_T);
        wait_for(1, 1'b1, OD_T);
        wait_for(2, 1'b0, 2);
        chk_term(TERM_RELEASED);
        $display("%s done", name);
    endtask
    task automatic t_oc_od();
        set_cond(5'h04);
        wait_for(1, 1'b0, OC_T);
        chk({7'h00, drive.standby}, 8'h00);
        chk_term(TERM_GND_30K);
        set_cond(5'h0c);
        wait_for(2, 1'b1, OD_T);
        chk_term(TERM_VDD_200K);
        clear("oc_od");
    endtask
    task automatic t_od_oc();
        set_cond(5'h08);
        wait_for(2, 1'b1, OD_T);
        set_cond(5'h0c);
        hold(OC_T);
        chk_term(TERM_VDD_200K);
        // an aborted over-current leaves nothing to release, so the gate returns at once
        set_cond(5'h00);
        repeat (5) @(posedge mclk);
        chk({7'h00, drive.dis_gate}, 8'h01);
        clear("od_oc");
    endtask
    task automatic t_test_pin();
        test_sel <= 1'b0;
        set_cond(5'h04);
        hold(OCUR_DLY_TICKS - 2);
        chk({7'h00, drive.dis_gate}, 8'h01);
        wait_for(1, 1'b0, 5);
        test_sel <= 1'b1;
        clear("test_pin");
        set_cond(5'h02);
        repeat (SHORT_DLY_CYCLES - 10) @(posedge mclk);
        chk({7'h00, drive.dis_gate}, 8'h01);
        wait_for(1, 1'b0, 1);
        chk_term(TERM_GND_30K);
        clear("short");
    endtask
    task automatic t_oc_ovc();
        set_cond(5'h04);
        wait_for(1, 1'b0, OC_T);
        set_cond(5'h14);
        wait_for(0, 1'b0, OVC_T);
        chk_term(TERM_GND_30K);
        clear("oc_ovc");
    endtask
    task automatic t_ovc_oc();
        set_cond(5'h10);
        wait_for(0, 1'b0, OVC_T);
        set_cond(5'h14);
        hold(OC_T);
        chk({7'h00, drive.dis_gate}, 8'h01);
        chk_term(TERM_RELEASED);
        clear("ovc_oc");
    endtask
    task automatic t_ovc_od();
        set_cond(5'h18);
        hold(OD_T);
        chk({7'h00, drive.dis_gate}, 8'h01);
        wait_for(0, 1'b0, OVC_T);
        wait_for(1, 1'b0, OD_T);
        chk({7'h00, drive.standby}, 8'h00);
        chk_term(TERM_VDD_200K);
        clear("ovc_od");
    endtask
    task automatic t_xs();
        set_cond(5'h08);
        wait_for(2, 1'b1, OD_T);
        set_cond(5'h09);
        hold(XS_T);
        chk({7'h00, drive.chg_gate}, 8'h01);
        set_cond(5'h01);
        wait_for(1, 1'b1, OD_T);
        chk({7'h00, drive.chg_gate}, 8'h01);
        wait_for(0, 1'b0, XS_T);
        clear("xs");
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        errors = 0;
        tests_run = 0;
        nrst = 1'b0;
        cond = '0;
        test_sel = 1'b1;
        repeat (10) @(posedge mclk);
        nrst <= 1'b1;
        repeat (6) @(posedge mclk);
        t_oc_od();
        t_od_oc();
        t_test_pin();
        t_oc_ovc();
        t_ovc_oc();
        t_ovc_od();
        t_xs();
        final_report();
    end
    initial begin
        repeat (90000) @(posedge mclk);
        errors++;
        final_report();
    end
endmodule // protection_fault_arbiter_tb
